// ---- hdl/ioxp_defs.svh ----
// Constants of the output port expander: address prefix, register map, timing counts.
// Assumes inclusion by bare name from the expander top module.
`ifndef IOXP_DEFS_SVH
`define IOXP_DEFS_SVH

`define IOXP_ADDR_PREFIX 3'h5
`define IOXP_BITS_PER_BYTE 4'h8
`define IOXP_LAST_ADDR_BIT 4'h7
`define IOXP_INIT_LOAD_CLASS 2'h2
`define IOXP_INIT_LOAD_PORTS 2'h3
`define IOXP_GROUP_HIGH 4'hf
`define IOXP_GROUP_LOW 4'h0

`define IOXP_OFS_CTRL 4'h0
`define IOXP_OFS_STATUS 4'h4
`define IOXP_OFS_PORTS 4'h8
`define IOXP_CTRL_EN_BIT 0
`define IOXP_CTRL_RESET 1'b1
`define IOXP_ST_ADDR_LSB 0
`define IOXP_ST_BUSY_BIT 8
`define IOXP_ST_READ_BIT 9
`define IOXP_ST_LOW_CLASS_LSB 12
`define IOXP_ST_HIGH_CLASS_LSB 14
`define IOXP_PORTS_OUT_LSB 0
`define IOXP_PORTS_PIN_LSB 8

`endif

// ---- hdl/ioxp_pkg.sv ----
// Types shared by the output port expander modules.
// Assumes nothing of its surroundings.
package ioxp_pkg;
    typedef enum logic [1:0] {
        STRAP_GND,
        STRAP_SUPPLY,
        STRAP_ON_SDA,
        STRAP_ON_SCL
    } ioxp_strap_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_DATA,
        ST_RD_ACK,
        ST_IGNORE
    } ioxp_state_t;
endpackage : ioxp_pkg

// ---- hdl/ioxp_link_if.sv ----
// Carrier of the synchronised bus view from the expander core to its strap classifiers.
// Assumes all signals are on clk_i of the core.
`timescale 1ns/1ps
`default_nettype none
interface ioxp_link_if;
    logic scl;
    logic sda;
    logic start;
    logic observe;
    logic done;
    logic load_level;
    modport core (output scl, sda, start, observe, done, load_level);
    modport watcher (input scl, sda, start, observe, done, load_level);
endinterface : ioxp_link_if
`default_nettype wire

// ---- hdl/ioxp_strap.sv ----
// Classifier of one four-level strap: ground, supply, tied to SDA or tied to SCL.
// Assumes strap, SCL and SDA already synchronised to clk_i.
`timescale 1ns/1ps
`default_nettype none
module ioxp_strap (
    input wire logic clk_i,
    input wire logic rst_i,
    ioxp_link_if.watcher link,
    input wire logic strap_i,
    output ioxp_pkg::ioxp_strap_t strap_class_o
);
    logic seen_hi;
    logic seen_lo;
    logic diff_scl;
    logic diff_sda;
    logic toggled;
    ioxp_pkg::ioxp_strap_t next_class;

    assign toggled = seen_hi & seen_lo;

    // A START makes SDA and SCL differ, so a strap cannot match both during the window.
    always_comb begin
        if (toggled && !diff_sda) begin
            next_class = ioxp_pkg::STRAP_ON_SDA;
        end else if (toggled && !diff_scl) begin
            next_class = ioxp_pkg::STRAP_ON_SCL;
        end else if (strap_i) begin
            next_class = ioxp_pkg::STRAP_SUPPLY;
        end else begin
            next_class = ioxp_pkg::STRAP_GND;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen_hi <= 1'b0;
            seen_lo <= 1'b0;
            diff_scl <= 1'b0;
            diff_sda <= 1'b0;
        end else if (link.start) begin
            seen_hi <= strap_i;
            seen_lo <= ~strap_i;
            diff_scl <= strap_i ^ link.scl;
            diff_sda <= strap_i ^ link.sda;
        end else if (link.observe) begin
            seen_hi <= seen_hi | strap_i;
            seen_lo <= seen_lo | ~strap_i;
            diff_scl <= diff_scl | (strap_i ^ link.scl);
            diff_sda <= diff_sda | (strap_i ^ link.sda);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_class_o <= ioxp_pkg::STRAP_GND;
        end else if (link.load_level) begin
            strap_class_o <= strap_i ? ioxp_pkg::STRAP_SUPPLY : ioxp_pkg::STRAP_GND;
        end else if (link.done) begin
            strap_class_o <= next_class;
        end
    end
endmodule : ioxp_strap
`default_nettype wire

// ---- hdl/ioxp_top.sv ----
// Summary of operation
// - Answer only target addresses whose top three bits are one, zero, one.
// - Classify each strap as ground, supply, SDA or SCL; sixteen addresses result.
// - High strap SCL/SDA/ground/supply gives 00/01/10/11; low strap ground/supply/SCL/SDA.
// - Re-decode straps and address on every transmission, whatever its target.
// - Until the first transmission, straps read only as supply or ground.
// - Low strap picks power-up level of ports 3..0, high strap ports 7..4.
// - Strap not at ground gives high default for its group; ground gives low.
// - A received data byte updates all eight outputs at once.
// - Idle bus is high; detect START and STOP while SCL is high.
// - One bit per SCL pulse; SDA stays stable while SCL is high.
// - Ninth clock carries acknowledge, pulled low by the receiving party.
// - Eighth bit after address start is direction: low write, high read.
// - SDA is input and open-drain output; SCL is input only.
// - A read returns bytes of the port levels read back as inputs until the master does not acknowledge.
// - Sample port levels in each acknowledge; next read byte carries that sample.
// - Multibyte write: acknowledge and apply each byte until STOP.
// - Bus-clear low aborts the transfer to stopped state, outputs untouched.
//
// Top of the I2C output port expander with a classic Wishbone register slave.
// Assumes SCL, SDA, straps, bus clear and port readback are asynchronous pins.
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ioxp_defs.svh"
module ioxp_top #(
    parameter int ADR_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_strap_low_i,
    input wire logic addr_strap_high_i,
    input wire logic bus_clr_n_i,
    input wire logic [7:0] port_level_i,
    output logic [7:0] output_ports_o
);
    // The register map decodes four offset bits, so a narrower address cannot reach it.
    if (ADR_W < 4) begin : g_adr_w_check
        $error("ioxp_top: ADR_W must be at least 4");
    end

    // High strap encodes the upper two variable address bits.
    function automatic logic [1:0] ioxp_enc_high(input ioxp_pkg::ioxp_strap_t c);
        unique case (c)
            ioxp_pkg::STRAP_ON_SCL: ioxp_enc_high = 2'h0;
            ioxp_pkg::STRAP_ON_SDA: ioxp_enc_high = 2'h1;
            ioxp_pkg::STRAP_GND: ioxp_enc_high = 2'h2;
            ioxp_pkg::STRAP_SUPPLY: ioxp_enc_high = 2'h3;
        endcase
    endfunction : ioxp_enc_high

    // Low strap encodes the lower two variable address bits.
    function automatic logic [1:0] ioxp_enc_low(input ioxp_pkg::ioxp_strap_t c);
        unique case (c)
            ioxp_pkg::STRAP_GND: ioxp_enc_low = 2'h0;
            ioxp_pkg::STRAP_SUPPLY: ioxp_enc_low = 2'h1;
            ioxp_pkg::STRAP_ON_SCL: ioxp_enc_low = 2'h2;
            ioxp_pkg::STRAP_ON_SDA: ioxp_enc_low = 2'h3;
        endcase
    endfunction : ioxp_enc_low

    function automatic logic [3:0] ioxp_group_default(input ioxp_pkg::ioxp_strap_t c);
        ioxp_group_default = (c == ioxp_pkg::STRAP_GND) ? `IOXP_GROUP_LOW : `IOXP_GROUP_HIGH;
    endfunction : ioxp_group_default

    // Two-flop synchronisers; the third SCL/SDA stage only serves edge detection.
    logic scl_meta, scl_s, scl_d;
    logic sda_meta, sda_s, sda_d;
    logic strap_lo_meta, strap_lo_s;
    logic strap_hi_meta, strap_hi_s;
    logic clr_meta, clr_n_s;
    logic [7:0] pin_meta, pin_s;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_meta <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_meta <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            clr_meta <= 1'b1;
            clr_n_s <= 1'b1;
        end else begin
            scl_meta <= scl_i;
            scl_s <= scl_meta;
            scl_d <= scl_s;
            sda_meta <= sda_i;
            sda_s <= sda_meta;
            sda_d <= sda_s;
            clr_meta <= bus_clr_n_i;
            clr_n_s <= clr_meta;
        end
    end

    always_ff @(posedge clk_i) begin
        strap_lo_meta <= addr_strap_low_i;
        strap_lo_s <= strap_lo_meta;
        strap_hi_meta <= addr_strap_high_i;
        strap_hi_s <= strap_hi_meta;
        pin_meta <= port_level_i;
        pin_s <= pin_meta;
    end

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

    ioxp_pkg::ioxp_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic read_dir;
    logic master_ack;
    logic [1:0] init_cnt;
    logic ctrl_en;
    ioxp_pkg::ioxp_strap_t low_class, high_class;

    wire [6:0] my_addr = {`IOXP_ADDR_PREFIX, ioxp_enc_high(high_class),
        ioxp_enc_low(low_class)};
    wire addr_match = ctrl_en && (rx_shift[7:1] == my_addr);
    wire byte_done = (bit_cnt == `IOXP_BITS_PER_BYTE);
    wire abort = ~clr_n_s;

    ioxp_link_if link ();
    assign link.scl = scl_s;
    assign link.sda = sda_s;
    assign link.start = start_det & ~abort;
    assign link.observe = (state == ioxp_pkg::ST_ADDR);
    assign link.done = (state == ioxp_pkg::ST_ADDR) && scl_rise
        && (bit_cnt == `IOXP_LAST_ADDR_BIT);
    assign link.load_level = (init_cnt == `IOXP_INIT_LOAD_CLASS);

    ioxp_strap u_strap_low (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .link(link.watcher),
        .strap_i(strap_lo_s),
        .strap_class_o(low_class)
    );

    ioxp_strap u_strap_high (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .link(link.watcher),
        .strap_i(strap_hi_s),
        .strap_class_o(high_class)
    );

    // Waits for synchronisers to settle before the power-up strap sample is trusted.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_cnt <= 2'h0;
        end else if (init_cnt != `IOXP_INIT_LOAD_PORTS) begin
            init_cnt <= init_cnt + 2'h1;
        end
    end

    // Serial engine. SDA changes while SCL is low, after the falling edge, except on bus clear.
    always_ff @(posedge clk_i) begin
        if (rst_i || abort) begin
            state <= ioxp_pkg::ST_IDLE;
            sda_oe_o <= 1'b0;
            bit_cnt <= 4'h0;
        end else if (start_det) begin
            state <= ioxp_pkg::ST_ADDR;
            sda_oe_o <= 1'b0;
            bit_cnt <= 4'h0;
        end else if (stop_det) begin
            state <= ioxp_pkg::ST_IDLE;
            sda_oe_o <= 1'b0;
        end else begin
            unique case (state)
                ioxp_pkg::ST_IDLE, ioxp_pkg::ST_IGNORE: begin
                    sda_oe_o <= 1'b0;
                end
                ioxp_pkg::ST_ADDR, ioxp_pkg::ST_WR_DATA: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        bit_cnt <= 4'h0;
                        if (state == ioxp_pkg::ST_WR_DATA) begin
                            sda_oe_o <= 1'b1;
                            state <= ioxp_pkg::ST_WR_ACK;
                        end else if (addr_match) begin
                            sda_oe_o <= 1'b1;
                            state <= ioxp_pkg::ST_ADDR_ACK;
                        end else begin
                            state <= ioxp_pkg::ST_IGNORE;
                        end
                    end
                end
                ioxp_pkg::ST_ADDR_ACK, ioxp_pkg::ST_WR_ACK: begin
                    if (scl_fall) begin
                        if (read_dir) begin
                            sda_oe_o <= ~tx_shift[7];
                            state <= ioxp_pkg::ST_RD_DATA;
                        end else begin
                            sda_oe_o <= 1'b0;
                            state <= ioxp_pkg::ST_WR_DATA;
                        end
                    end
                end
                ioxp_pkg::ST_RD_DATA: begin
                    if (scl_fall) begin
                        if (bit_cnt == `IOXP_LAST_ADDR_BIT) begin
                            bit_cnt <= 4'h0;
                            sda_oe_o <= 1'b0;
                            state <= ioxp_pkg::ST_RD_ACK;
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                            sda_oe_o <= ~tx_shift[6];
                        end
                    end
                end
                ioxp_pkg::ST_RD_ACK: begin
                    if (scl_fall) begin
                        if (master_ack) begin
                            sda_oe_o <= ~tx_shift[7];
                            state <= ioxp_pkg::ST_RD_DATA;
                        end else begin
                            state <= ioxp_pkg::ST_IGNORE;
                        end
                    end
                end
            endcase
        end
    end

    // Data path: receive shift, transmit shift, direction and port sampling.
    wire in_ack = (state == ioxp_pkg::ST_ADDR_ACK) || (state == ioxp_pkg::ST_WR_ACK)
        || (state == ioxp_pkg::ST_RD_ACK);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_shift <= 8'h00;
            tx_shift <= 8'h00;
            read_dir <= 1'b0;
            master_ack <= 1'b0;
        end else begin
            if (scl_rise && ((state == ioxp_pkg::ST_ADDR) || (state == ioxp_pkg::ST_WR_DATA))) begin
                rx_shift <= {rx_shift[6:0], sda_s};
            end
            if (state == ioxp_pkg::ST_ADDR && scl_fall && byte_done) begin
                read_dir <= rx_shift[0];
            end
            if (scl_rise && in_ack) begin
                tx_shift <= pin_s;
                master_ack <= ~sda_s;
            end else if (scl_fall && state == ioxp_pkg::ST_RD_DATA) begin
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
    end

    // Output register: power-up defaults once, then every written byte in one step.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            output_ports_o <= 8'h00;
        // The load strobe lasts one cycle, so a later idle bus never restores the defaults.
        end else if (link.load_level) begin
            output_ports_o <= {ioxp_group_default(ioxp_pkg::ioxp_strap_t'({1'b0, strap_hi_s})),
                ioxp_group_default(ioxp_pkg::ioxp_strap_t'({1'b0, strap_lo_s}))};
        end else if (!abort && !start_det && !stop_det && state == ioxp_pkg::ST_WR_DATA
            && scl_fall && byte_done) begin
            output_ports_o <= rx_shift;
        end
    end

    // SDA is open drain: the data level is always low, only the enable moves.
    always_ff @(posedge clk_i) begin
        sda_o <= 1'b0;
    end

    // Wishbone slave: ack one cycle after the request, write lands on the ack edge.
    wire wb_req = wb_cyc_i & wb_stb_i;
    wire [3:0] wb_ofs = wb_adr_i[3:0];
    wire wb_write = wb_req & wb_ack_o & wb_we_i & wb_sel_i[0];
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (wb_ofs)
            `IOXP_OFS_CTRL: begin
                rd_word[`IOXP_CTRL_EN_BIT] = ctrl_en;
            end
            `IOXP_OFS_STATUS: begin
                rd_word[`IOXP_ST_ADDR_LSB +: 7] = my_addr;
                rd_word[`IOXP_ST_BUSY_BIT] = (state != ioxp_pkg::ST_IDLE);
                rd_word[`IOXP_ST_READ_BIT] = read_dir;
                rd_word[`IOXP_ST_LOW_CLASS_LSB +: 2] = low_class;
                rd_word[`IOXP_ST_HIGH_CLASS_LSB +: 2] = high_class;
            end
            `IOXP_OFS_PORTS: begin
                rd_word[`IOXP_PORTS_OUT_LSB +: 8] = output_ports_o;
                rd_word[`IOXP_PORTS_PIN_LSB +: 8] = pin_s;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            wb_dat_o <= (wb_req & ~wb_ack_o & ~wb_we_i) ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_en <= `IOXP_CTRL_RESET;
        end else if (wb_write && wb_ofs == `IOXP_OFS_CTRL) begin
            ctrl_en <= wb_dat_i[`IOXP_CTRL_EN_BIT];
        end
    end
endmodule : ioxp_top
`default_nettype wire

// ---- test/ioxp_top_sva.sv ----
// Pin-level checks of the output port expander top.
// Assumes it is bound to ioxp_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ioxp_top_sva #(
    parameter int ADR_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic addr_strap_low_i,
    input wire logic addr_strap_high_i,
    input wire logic bus_clr_n_i,
    input wire logic [7:0] port_level_i,
    input wire logic [7:0] output_ports_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Power-up defaults load a few cycles after reset, so early output moves are not writes.
    logic [3:0] up_cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            up_cnt <= 4'h0;
        end else if (up_cnt != 4'hf) begin
            up_cnt <= up_cnt + 4'h1;
        end
    end
    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_scl_high;
        (scl_i && bus_clr_n_i) [*3];
    endsequence
    AST_WB_ANSWER: assert property (s_wb_req |=> wb_ack_o)
        else $error("bus request not answered after one cycle");
    AST_WB_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge longer than one cycle");
    AST_WB_QUIET: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data present without acknowledge");
    AST_RESET_QUIET: assert property ($fell(rst_i) |-> !sda_oe_o && output_ports_o == 8'h00)
        else $error("outputs not cleared by reset");
    AST_SDA_OPEN_DRAIN: assert property (!sda_o)
        else $error("data line driven high");
    AST_SDA_STABLE: assert property (s_scl_high |-> $stable(sda_oe_o))
        else $error("data line changed while clock high");
    AST_CLEAR_RELEASES: assert property ($fell(bus_clr_n_i) |-> ##[1:6] !sda_oe_o)
        else $error("bus clear did not release the data line");
    AST_CLEAR_KEEPS: assert property (
        !bus_clr_n_i && !$past(bus_clr_n_i, 3) |-> $stable(output_ports_o))
        else $error("bus clear changed the outputs");
    AST_WRITE_ACKED: assert property (
        up_cnt == 4'hf && $changed(output_ports_o) |-> ##[0:2] sda_oe_o)
        else $error("outputs changed without an acknowledged byte");
endmodule : ioxp_top_sva
`default_nettype wire

// ---- test/ioxp_bfm.sv ----
// Behavioural bus master: frames every transfer and makes every clock pulse.
// Assumes the bench resolves the open-drain data wire and feeds it back on sda_i.
`timescale 1ns/1ps
`default_nettype none
module ioxp_bfm (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    // Extra low-phase cycles; the bench raises it to run the bus slowly.
    int slow;
    initial begin
        slow = 0;
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    // Data moves two cycles after the clock falls, so it never races the clock edge.
    task automatic bit_cycle(input logic drive, input logic b, output logic got);
        scl_o <= 1'b0;
        tick(2);
        sda_oe_o <= drive && !b;
        tick(2 + slow);
        scl_o <= 1'b1;
        tick(2);
        got = sda_i;
        tick(2);
    endtask : bit_cycle
    task automatic cond(input logic pull_first);
        scl_o <= 1'b0;
        tick(2);
        sda_oe_o <= pull_first;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_oe_o <= !pull_first;
        tick(4);
    endtask : cond
    task automatic start();
        cond(1'b0);
    endtask : start
    task automatic stop();
        cond(1'b1);
    endtask : stop
    task automatic wr_byte(input logic [7:0] d, output logic ack_n);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d[i], g);
        end
        bit_cycle(1'b0, 1'b0, ack_n);
    endtask : wr_byte
    task automatic rd_byte(output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b0, 1'b0, d[i]);
        end
    endtask : rd_byte
endmodule : ioxp_bfm
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench of the output port expander: bus master, straps, bus clear, registers.
// Assumes package, expander, bus master model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int ADR_W = 4;
    // Address bits per strap class, indexed ground, supply, SDA, SCL.
    localparam logic [7:0] HI_ENC = {2'h0, 2'h1, 2'h3, 2'h2};
    localparam logic [7:0] LO_ENC = {2'h2, 2'h3, 2'h1, 2'h0};
    localparam logic [6:0] ADDR = {3'h5, HI_ENC[1:0], LO_ENC[3:2]};
    logic clk, rst, cyc, stb, we, clr_n, ack, scl, sda_o, sda_oe, m_oe, sda_w;
    logic [3:0] adr, sel, lvl;
    logic [31:0] wdat, dat_o, got;
    logic [7:0] flip, outs;
    logic [1:0] lo_sel, hi_sel;
    int miscompares, checks_done;
    event hang;
    assign sda_w = !(m_oe || sda_oe);
    assign lvl = {scl, sda_w, 2'b10};
    ioxp_top #(.ADR_W(ADR_W)) ioxp_top_inst (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .addr_strap_low_i(lvl[lo_sel]), .addr_strap_high_i(lvl[hi_sel]),
        .bus_clr_n_i(clr_n), .port_level_i(outs ^ flip), .output_ports_o(outs));
    ioxp_bfm ioxp_bfm_inst (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(m_oe));
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk_val
    task automatic chk_ack(input logic g_n, input logic e);
        chk_val({31'h0, g_n}, {31'h0, !e});
    endtask : chk_ack
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            -> hang;
        end
        got = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb_xfer
    task automatic i2c_write(input logic [6:0] a, input logic [7:0] d, input logic e);
        logic g;
        ioxp_bfm_inst.start();
        ioxp_bfm_inst.wr_byte({a, 1'b0}, g);
        chk_ack(g, e);
        ioxp_bfm_inst.wr_byte(d, g);
        chk_ack(g, e);
        ioxp_bfm_inst.stop();
    endtask : i2c_write
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        fork
            repeat (100000) @(posedge clk);
            @(hang);
        join_any
        $display("Error at %0t: wait ran out", $time);
        miscompares++;
        finish_test();
    end
    initial begin
        logic [6:0] a;
        logic [7:0] d;
        logic g;
        {rst, cyc, stb, we, adr, wdat, sel, clr_n, flip} = {4'h8, 4'h0, 32'h0, 4'hf, 1'b1, 8'h0};
        miscompares = 0;
        checks_done = 0;
        // The bus idles high from time zero, so the SDA strap reads as supply.
        lo_sel = 2'h2;
        hi_sel = 2'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        chk_val({24'h0, outs}, 32'h0000000f);
        done("power-up defaults");
        for (int i = 0; i < 16; i++) begin
            hi_sel <= i[3:2];
            lo_sel <= i[1:0];
            a = {3'h5, HI_ENC[2*i[3:2] +: 2], LO_ENC[2*i[1:0] +: 2]};
            d = {i[3:0], ~i[3:0]};
            i2c_write(a, d, 1'b1);
            chk_val({24'h0, outs}, {24'h0, d});
            wb_xfer(1'b0, 4'h4, 32'h0);
            chk_val(got & 32'h0000f27f, {16'h0, i[3:2], i[1:0], 5'h0, a});
        end
        done("strap classes");
        hi_sel <= 2'h0;
        lo_sel <= 2'h1;
        ioxp_bfm_inst.start();
        ioxp_bfm_inst.wr_byte({ADDR, 1'b0}, g);
        chk_ack(g, 1'b1);
        for (int i = 0; i < 3; i++) begin
            d = 8'h3c + 8'(i) * 8'h47;
            ioxp_bfm_inst.wr_byte(d, g);
            chk_ack(g, 1'b1);
            chk_val({24'h0, outs}, {24'h0, d});
        end
        ioxp_bfm_inst.stop();
        done("multibyte write");
        flip <= 8'h81;
        ioxp_bfm_inst.slow = 4;
        ioxp_bfm_inst.start();
        ioxp_bfm_inst.wr_byte({ADDR, 1'b1}, g);
        chk_ack(g, 1'b1);
        ioxp_bfm_inst.rd_byte(got[7:0]);
        chk_val({24'h0, got[7:0]}, {24'h0, d ^ 8'h81});
        flip <= 8'h18;
        ioxp_bfm_inst.bit_cycle(1'b1, 1'b0, g);
        ioxp_bfm_inst.rd_byte(got[7:0]);
        chk_val({24'h0, got[7:0]}, {24'h0, d ^ 8'h18});
        ioxp_bfm_inst.bit_cycle(1'b1, 1'b1, g);
        ioxp_bfm_inst.stop();
        ioxp_bfm_inst.slow = 0;
        done("readback");
        hi_sel <= 2'h1;
        i2c_write(ADDR, 8'h11, 1'b0);
        i2c_write({3'h6, 4'hd}, 8'h11, 1'b0);
        chk_val({24'h0, outs}, {24'h0, d});
        wb_xfer(1'b0, 4'h4, 32'h0);
        chk_val(got & 32'h7f, {25'h0, 3'h5, HI_ENC[3:2], LO_ENC[3:2]});
        hi_sel <= 2'h0;
        done("address mismatch");
        wb_xfer(1'b0, 4'h0, 32'h0);
        chk_val(got, 32'h1);
        wb_xfer(1'b1, 4'h0, 32'h0);
        i2c_write(ADDR, 8'h55, 1'b0);
        wb_xfer(1'b1, 4'h0, 32'h1);
        i2c_write(ADDR, 8'h55, 1'b1);
        chk_val({24'h0, outs}, 32'h55);
        wb_xfer(1'b0, 4'hc, 32'h0);
        chk_val(got, 32'h0);
        done("registers");
        flip <= 8'h55;
        ioxp_bfm_inst.start();
        ioxp_bfm_inst.wr_byte({ADDR, 1'b1}, g);
        ioxp_bfm_inst.bit_cycle(1'b0, 1'b0, g);
        chk_val({31'h0, g}, 32'h0);
        clr_n <= 1'b0;
        repeat (6) @(posedge clk);
        clr_n <= 1'b1;
        repeat (6) @(posedge clk);
        ioxp_bfm_inst.bit_cycle(1'b0, 1'b0, g);
        chk_val({31'h0, g}, 32'h1);
        ioxp_bfm_inst.stop();
        chk_val({24'h0, outs}, 32'h55);
        i2c_write(ADDR, 8'h96, 1'b1);
        chk_val({24'h0, outs}, 32'h96);
        wb_xfer(1'b0, 4'h8, 32'h0);
        chk_val(got, 32'h0000c396);
        done("bus clear");
        finish_test();
    end
endmodule : tb
bind ioxp_top ioxp_top_sva #(.ADR_W(ADR_W)) ioxp_top_sva_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .addr_strap_low_i(addr_strap_low_i),
    .addr_strap_high_i(addr_strap_high_i), .bus_clr_n_i(bus_clr_n_i),
    .port_level_i(port_level_i), .output_ports_o(output_ports_o));
`default_nettype wire
